// ---- core/supervisor_defines.svh ----
// Purpose: constants of the supervisor output and watchdog logic
// Assumes: 40 MHz core clock
// Notes: definitions only
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// Register offsets
`define ADDR_OUT1_CTRL 8'h0c
`define ADDR_OUT2_CTRL 8'h0f
`define ADDR_OUT3_CTRL 8'h12
`define ADDR_OUT4_CTRL 8'h15
`define ADDR_OUT5_CTRL 8'h18
`define ADDR_OUT6_CTRL 8'h1b
`define ADDR_OUT7_CTRL 8'h1e
`define ADDR_OUT8_CTRL 8'h21
`define ADDR_OUT9_THR 8'h22
`define ADDR_OUT9_LOGIC 8'h23
`define ADDR_OUT9_CTRL 8'h24
`define ADDR_OUT10_THR 8'h25
`define ADDR_OUT10_LOGIC 8'h26
`define ADDR_OUT10_CTRL 8'h27
`define ADDR_WD_INPUT 8'h29
`define ADDR_WD_TIMING 8'h2a
`define ADDR_LOCK_SUPPLY 8'h2e
`define ADDR_CFG_FIRST 8'h0c
`define ADDR_NV_OFFSET 8'h80
`define CTRL_NONE 4'hf

// Field positions
`define LOGIC_DEP_WD 0
`define LOGIC_DEP_GPI_LSB 1
`define LOGIC_DEP_GPI_MSB 4
`define LOGIC_DEP_MR 5
`define WD_GPI_SEL_MSB 1
`define WD_GPI_SEL_LSB 0
`define WD_PO_SEL_MSB 5
`define WD_PO_SEL_LSB 2
`define WD_MODE_MSB 7
`define WD_MODE_LSB 6
`define WD_NORMAL_MSB 2
`define WD_NORMAL_LSB 0
`define WD_INITIAL_MSB 5
`define WD_INITIAL_LSB 3
`define WD_ENABLE 6
`define LOCK_BIT 0
`define WR_DISABLE_BIT 1
`define SUPPLY_EXT_BIT 2
`define WD_PO_COUNT 4'ha

// Timing
`define CLK_PERIOD_NS 25
`define TICK_TIME_NS 3125
`define TICK_TIME_NS_NUM 8
`define TICK_TIME_NS_DEN 25
`define DLY0_NS 25000
`define DLY1_NS 1562500
`define DLY2_NS 6250000
`define DLY3_NS 25000000
`define DLY4_NS 50000000
`define DLY5_NS 200000000
`define DLY6_NS 400000000
`define DLY7_NS 1600000000
`define WD0_US 6250
`define WD1_US 25000
`define WD2_US 100000
`define WD3_US 400000
`define WD4_US 1600000
`define WD5_US 6400000
`define WD6_US 25600000
`define WD7_US 102400000

// Reset values of filtered pins
`define PIN_RESET 14'h0002

`endif

// ---- core/supervisor_pkg.sv ----
// Purpose: types of the supervisor output and watchdog logic
// Assumes: nothing
// Notes: no constants here, see supervisor_defines.svh
package supervisor_pkg;

    typedef struct packed {
        logic [2:0] spare;
        logic [2:0] delay;
        logic active_high;
        logic open_drain;
    } ctrl_type;

    typedef struct packed {
        logic [7:0] undervoltage;
        logic [3:0] gpi;
        logic manual_reset_n;
        logic supply_good;
    } pins_type;

    typedef enum logic [0:0] {LOAD, RUN} load_state_type;

    typedef enum logic [1:0] {WD_OFF, WD_INITIAL, WD_NORMAL} wd_phase_type;

endpackage

// ---- core/deassert_timer.sv ----
// Purpose: holds one output asserted for its deassert delay
// Assumes: tick is a one-cycle pulse every TICK_TIME_NS
// Notes: delay restarts whenever the request is seen again
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"

module deassert_timer #(
    parameter int CNT_W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic request,
    input wire logic [2:0] delay_code,
    output logic asserted_q
);

    logic [CNT_W-1:0] count_q;

    function automatic logic [CNT_W-1:0] delay_ticks(input logic [2:0] code);
        case (code)
            3'h0: delay_ticks = CNT_W'(`DLY0_NS / `TICK_TIME_NS);
            3'h1: delay_ticks = CNT_W'(`DLY1_NS / `TICK_TIME_NS);
            3'h2: delay_ticks = CNT_W'(`DLY2_NS / `TICK_TIME_NS);
            3'h3: delay_ticks = CNT_W'(`DLY3_NS / `TICK_TIME_NS);
            3'h4: delay_ticks = CNT_W'(`DLY4_NS / `TICK_TIME_NS);
            3'h5: delay_ticks = CNT_W'(`DLY5_NS / `TICK_TIME_NS);
            3'h6: delay_ticks = CNT_W'(`DLY6_NS / `TICK_TIME_NS);
            default: delay_ticks = CNT_W'(`DLY7_NS / `TICK_TIME_NS);
        endcase
    endfunction

    // Asserted on request, released once the delay has run out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            asserted_q <= 1'b0;
            count_q <= '0;
        end else if (request) begin
            asserted_q <= 1'b1;
            count_q <= delay_ticks(delay_code);
        end else if (asserted_q && tick) begin
            if (count_q <= CNT_W'(1)) begin
                asserted_q <= 1'b0;
                count_q <= '0;
            end else begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end

endmodule

`default_nettype wire

// ---- core/supervisor_output_watchdog_logic.sv ----
// Purpose: output assertion, polarity, stage, deassert delay and watchdog
// Assumes: serial engine outside delivers byte register accesses
// Notes: configuration copy is read from nonvolatile memory after reset
//
// Operation
// - output nine threshold register bits 0-7 select undervoltage of inputs one-eight.
// - output nine logic register bit 0 selects watchdog, bits 1-4 logic inputs.
// - logic register bit 5 asserts output while manual reset low; bits 7:6 unused.
// - a zero dependency bit makes the output ignore that source.
// - output ten has the same pair of dependency registers.
// - control bit 1 selects polarity: zero asserts low, one asserts high.
// - each output has its own stage choice and deassert delay.
// - control bit 0 picks open drain, bits 4:2 the deassert delay.
// - watchdog fault asserts every output whose watchdog bit is set.
// - watchdog cleared by pulses on a logic input, an output, or both.
// - watchdog input register: bits 1:0 input, 5:2 output, 7:6 mode.
// - initial timeout after reset, reboot, reset event or enabling.
// - no clear within initial timeout raises a fault.
// - after initial phase ends the normal timeout applies.
// - no clear within normal timeout raises a fault.
// - timing register holds initial, normal timeout and enable.
// - three-bit codes 6.25ms to 102.4s; initial in bits 5:3; bit 6 enables.
// - lock bit refuses all configuration writes except to the lock register.
// - supply register bit 2 selects external supply when one.
// - user memory writes blocked while supplies collapse.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"

module supervisor_output_watchdog_logic #(
    parameter int TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS,
    parameter int NUM_OUT = 10,
    parameter int WD_CNT_W = 26
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_busy,
    output logic nvm_rd,
    output logic nvm_wr,
    output logic [7:0] nvm_addr,
    output logic [7:0] nvm_wdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic [7:0] undervoltage,
    input wire logic [3:0] general_logic_input,
    input wire logic manual_reset_input_n,
    input wire logic supply_good,
    input wire logic reboot_req,
    input wire logic [7:0] sequencer_request,
    input wire logic user_ee_wr_req,
    output logic user_ee_wr_en,
    output logic [NUM_OUT-1:0] programmable_output_o,
    output logic [NUM_OUT-1:0] programmable_output_oe,
    output logic [NUM_OUT-1:0] programmable_output_pullup,
    output logic external_supply_sel,
    output logic watchdog_fault
);

    logic rst_s1_q;
    logic rst_n_q;
    supervisor_pkg::pins_type pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
    logic [7:0] ctrl_q [NUM_OUT];
    logic [7:0] thr_dep_q [2];
    logic [7:0] logic_dep_q [2];
    logic [7:0] wd_input_q;
    logic [7:0] wd_timing_q;
    logic [7:0] lock_supply_q;
    supervisor_pkg::load_state_type load_state_q;
    logic [7:0] load_addr_q;
    logic load_pend_q;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic host_wr_ok;
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_q;
    logic tick_q;
    logic [NUM_OUT-1:0] request;
    logic [NUM_OUT-1:0] asserted;
    supervisor_pkg::wd_phase_type wd_phase_q;
    logic [WD_CNT_W-1:0] wd_cnt_q;
    logic [WD_CNT_W-1:0] wd_limit;
    logic wd_en_q;
    logic gpi_prev_q;
    logic po_prev_q;
    logic gpi_seen_q;
    logic po_seen_q;
    logic gpi_sel;
    logic po_sel;
    logic gpi_pulse;
    logic po_pulse;
    logic wd_clear;
    logic wd_restart;

    function automatic logic [3:0] ctrl_index(input logic [7:0] addr);
        case (addr)
            `ADDR_OUT1_CTRL: ctrl_index = 4'h0;
            `ADDR_OUT2_CTRL: ctrl_index = 4'h1;
            `ADDR_OUT3_CTRL: ctrl_index = 4'h2;
            `ADDR_OUT4_CTRL: ctrl_index = 4'h3;
            `ADDR_OUT5_CTRL: ctrl_index = 4'h4;
            `ADDR_OUT6_CTRL: ctrl_index = 4'h5;
            `ADDR_OUT7_CTRL: ctrl_index = 4'h6;
            `ADDR_OUT8_CTRL: ctrl_index = 4'h7;
            `ADDR_OUT9_CTRL: ctrl_index = 4'h8;
            `ADDR_OUT10_CTRL: ctrl_index = 4'h9;
            default: ctrl_index = `CTRL_NONE;
        endcase
    endfunction

    function automatic logic [WD_CNT_W-1:0] wd_ticks(input logic [2:0] code);
        case (code)
            3'h0: wd_ticks = WD_CNT_W'(`WD0_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
            3'h1: wd_ticks = WD_CNT_W'(`WD1_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
            3'h2: wd_ticks = WD_CNT_W'(`WD2_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
            3'h3: wd_ticks = WD_CNT_W'(`WD3_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
            3'h4: wd_ticks = WD_CNT_W'(`WD4_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
            3'h5: wd_ticks = WD_CNT_W'(`WD5_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
            3'h6: wd_ticks = WD_CNT_W'(`WD6_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
            default: wd_ticks = WD_CNT_W'(`WD7_US * `TICK_TIME_NS_NUM / `TICK_TIME_NS_DEN);
        endcase
    endfunction

    // Reset release
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Pin filter, a change counts once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_s1_q <= `PIN_RESET;
            pin_s2_q <= `PIN_RESET;
            pin_s3_q <= `PIN_RESET;
            pin_q <= `PIN_RESET;
        end else begin
            pin_s1_q <= {undervoltage, general_logic_input, manual_reset_input_n, supply_good};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
        end
    end

    // Time base
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == $bits(tick_cnt_q)'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // Host writes, refused while loading or locked
    assign host_wr_ok = reg_wr && load_state_q == supervisor_pkg::RUN &&
        (!lock_supply_q[`LOCK_BIT] || reg_addr == `ADDR_LOCK_SUPPLY ||
         reg_addr == (`ADDR_LOCK_SUPPLY | `ADDR_NV_OFFSET));

    always_comb begin
        if (load_state_q == supervisor_pkg::LOAD) begin
            wr_en = load_pend_q;
            wr_addr = load_addr_q;
            wr_data = nvm_rdata;
        end else begin
            wr_en = host_wr_ok && reg_addr < `ADDR_NV_OFFSET;
            wr_addr = reg_addr;
            wr_data = reg_wdata;
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                ctrl_q[i] <= '0;
            end
            thr_dep_q[0] <= '0;
            thr_dep_q[1] <= '0;
            logic_dep_q[0] <= '0;
            logic_dep_q[1] <= '0;
            wd_input_q <= '0;
            wd_timing_q <= '0;
            lock_supply_q <= '0;
        end else if (wr_en) begin
            if (ctrl_index(wr_addr) != `CTRL_NONE) begin
                ctrl_q[ctrl_index(wr_addr)] <= wr_data;
            end
            case (wr_addr)
                `ADDR_OUT9_THR: thr_dep_q[0] <= wr_data;
                `ADDR_OUT9_LOGIC: logic_dep_q[0] <= wr_data;
                `ADDR_OUT10_THR: thr_dep_q[1] <= wr_data;
                `ADDR_OUT10_LOGIC: logic_dep_q[1] <= wr_data;
                `ADDR_WD_INPUT: wd_input_q <= wr_data;
                `ADDR_WD_TIMING: wd_timing_q <= wr_data;
                `ADDR_LOCK_SUPPLY: lock_supply_q <= wr_data;
                default: ;
            endcase
        end
    end

    // Nonvolatile load after reset and config memory writes
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            load_state_q <= supervisor_pkg::LOAD;
            load_addr_q <= `ADDR_CFG_FIRST;
            load_pend_q <= 1'b0;
            nvm_rd <= 1'b0;
            nvm_wr <= 1'b0;
            nvm_addr <= '0;
            nvm_wdata <= '0;
        end else begin
            nvm_wr <= 1'b0;
            case (load_state_q)
                supervisor_pkg::LOAD: begin
                    if (!nvm_rd && !load_pend_q) begin
                        nvm_rd <= 1'b1;
                        nvm_addr <= load_addr_q | `ADDR_NV_OFFSET;
                    end else if (nvm_rd) begin
                        nvm_rd <= 1'b0;
                        load_pend_q <= 1'b1;
                    end else begin
                        load_pend_q <= 1'b0;
                        if (load_addr_q == `ADDR_LOCK_SUPPLY) begin
                            load_state_q <= supervisor_pkg::RUN;
                        end else begin
                            load_addr_q <= load_addr_q + 1'b1;
                        end
                    end
                end
                supervisor_pkg::RUN: begin
                    if (host_wr_ok && reg_addr >= `ADDR_NV_OFFSET) begin
                        nvm_wr <= 1'b1;
                        nvm_addr <= reg_addr;
                        nvm_wdata <= reg_wdata;
                    end
                end
                default: load_state_q <= supervisor_pkg::RUN;
            endcase
        end
    end

    // Register reads
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= '0;
            reg_busy <= 1'b1;
        end else begin
            reg_busy <= load_state_q == supervisor_pkg::LOAD;
            if (reg_rd) begin
                if (ctrl_index(reg_addr) != `CTRL_NONE) begin
                    reg_rdata <= ctrl_q[ctrl_index(reg_addr)];
                end else begin
                    case (reg_addr)
                        `ADDR_OUT9_THR: reg_rdata <= thr_dep_q[0];
                        `ADDR_OUT9_LOGIC: reg_rdata <= logic_dep_q[0];
                        `ADDR_OUT10_THR: reg_rdata <= thr_dep_q[1];
                        `ADDR_OUT10_LOGIC: reg_rdata <= logic_dep_q[1];
                        `ADDR_WD_INPUT: reg_rdata <= wd_input_q;
                        `ADDR_WD_TIMING: reg_rdata <= wd_timing_q;
                        `ADDR_LOCK_SUPPLY: reg_rdata <= lock_supply_q;
                        default: reg_rdata <= '0;
                    endcase
                end
            end
        end
    end

    // Assertion requests
    always_comb begin
        request = '0;
        request[7:0] = sequencer_request;
        for (int k = 0; k < 2; k++) begin
            request[8 + k] = |(pin_q.undervoltage & thr_dep_q[k]) ||
                (logic_dep_q[k][`LOGIC_DEP_WD] && watchdog_fault) ||
                |(pin_q.gpi & logic_dep_q[k][`LOGIC_DEP_GPI_MSB:`LOGIC_DEP_GPI_LSB]) ||
                (logic_dep_q[k][`LOGIC_DEP_MR] && !pin_q.manual_reset_n);
        end
    end

    // Per-output delay, polarity and stage
    for (genvar g = 0; g < NUM_OUT; g++) begin : gen_out
        supervisor_pkg::ctrl_type ctrl;
        assign ctrl = supervisor_pkg::ctrl_type'(ctrl_q[g]);

        deassert_timer u_timer (
            .clk(core_clk),
            .rst_n(rst_n_q),
            .tick(tick_q),
            .request(request[g]),
            .delay_code(ctrl.delay),
            .asserted_q(asserted[g])
        );

        always_ff @(posedge core_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                programmable_output_o[g] <= 1'b0;
                programmable_output_oe[g] <= 1'b0;
                programmable_output_pullup[g] <= 1'b0;
            end else begin
                programmable_output_o[g] <= asserted[g] ~^ ctrl.active_high;
                programmable_output_oe[g] <= !(asserted[g] ~^ ctrl.active_high);
                programmable_output_pullup[g] <= !ctrl.open_drain;
            end
        end
    end

    // Watchdog clear sources
    assign gpi_sel = pin_q.gpi[wd_input_q[`WD_GPI_SEL_MSB:`WD_GPI_SEL_LSB]];
    assign po_sel = wd_input_q[`WD_PO_SEL_MSB:`WD_PO_SEL_LSB] < `WD_PO_COUNT &&
        asserted[wd_input_q[`WD_PO_SEL_MSB:`WD_PO_SEL_LSB]];
    assign gpi_pulse = gpi_sel && !gpi_prev_q;
    assign po_pulse = po_sel && !po_prev_q;

    always_comb begin
        case (wd_input_q[`WD_MODE_MSB:`WD_MODE_LSB])
            2'h1: wd_clear = gpi_pulse;
            2'h2: wd_clear = po_pulse;
            2'h3: wd_clear = (gpi_pulse || gpi_seen_q) && (po_pulse || po_seen_q);
            default: wd_clear = 1'b0;
        endcase
    end

    assign wd_restart = reboot_req || !pin_q.manual_reset_n ||
        (wd_timing_q[`WD_ENABLE] && !wd_en_q);
    assign wd_limit = wd_phase_q == supervisor_pkg::WD_INITIAL ?
        wd_ticks(wd_timing_q[`WD_INITIAL_MSB:`WD_INITIAL_LSB]) :
        wd_ticks(wd_timing_q[`WD_NORMAL_MSB:`WD_NORMAL_LSB]);

    // Pulse capture for the both mode
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gpi_prev_q <= 1'b0;
            po_prev_q <= 1'b0;
            gpi_seen_q <= 1'b0;
            po_seen_q <= 1'b0;
        end else begin
            gpi_prev_q <= gpi_sel;
            po_prev_q <= po_sel;
            if (wd_clear || wd_restart) begin
                gpi_seen_q <= 1'b0;
                po_seen_q <= 1'b0;
            end else begin
                gpi_seen_q <= gpi_seen_q || gpi_pulse;
                po_seen_q <= po_seen_q || po_pulse;
            end
        end
    end

    // Watchdog timer
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wd_phase_q <= supervisor_pkg::WD_OFF;
            wd_cnt_q <= '0;
            wd_en_q <= 1'b0;
            watchdog_fault <= 1'b0;
        end else begin
            wd_en_q <= wd_timing_q[`WD_ENABLE];
            watchdog_fault <= 1'b0;
            if (!wd_timing_q[`WD_ENABLE] || load_state_q == supervisor_pkg::LOAD) begin
                wd_phase_q <= supervisor_pkg::WD_OFF;
                wd_cnt_q <= '0;
            end else if (wd_restart || wd_phase_q == supervisor_pkg::WD_OFF) begin
                wd_phase_q <= supervisor_pkg::WD_INITIAL;
                wd_cnt_q <= '0;
            end else if (wd_clear) begin
                wd_phase_q <= supervisor_pkg::WD_NORMAL;
                wd_cnt_q <= '0;
            end else if (tick_q && wd_input_q[`WD_MODE_MSB:`WD_MODE_LSB] != 2'h0) begin
                if (wd_cnt_q + 1'b1 >= wd_limit) begin
                    watchdog_fault <= 1'b1;
                    wd_phase_q <= supervisor_pkg::WD_INITIAL;
                    wd_cnt_q <= '0;
                end else begin
                    wd_cnt_q <= wd_cnt_q + 1'b1;
                end
            end
        end
    end

    // Supply select and user memory write gate
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            external_supply_sel <= 1'b0;
            user_ee_wr_en <= 1'b0;
        end else begin
            external_supply_sel <= lock_supply_q[`SUPPLY_EXT_BIT];
            user_ee_wr_en <= user_ee_wr_req &&
                (pin_q.supply_good || !lock_supply_q[`WR_DISABLE_BIT]);
        end
    end

endmodule

`default_nettype wire

// ---- tb/sowl_assertions.sv ----
// Purpose: port checks of the output and watchdog logic
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module sowl_assertions (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_busy,
    input wire logic nvm_rd,
    input wire logic nvm_wr,
    input wire logic user_ee_wr_req,
    input wire logic user_ee_wr_en,
    input wire logic external_supply_sel,
    input wire logic watchdog_fault
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence load_gap;
        !nvm_rd ##1 !nvm_rd;
    endsequence
    sequence supply_wr;
        reg_wr && !reg_busy && reg_addr == 8'h2e;
    endsequence
    a_load_gap: assert property (nvm_rd |=> load_gap)
        else $error("load gap");
    a_load_busy: assert property (nvm_rd |-> reg_busy)
        else $error("load idle");
    a_load_no_wr: assert property (reg_busy |-> !nvm_wr)
        else $error("write in load");
    a_nvm_wr_cause: assert property (nvm_wr |-> $past(reg_wr && reg_addr[7]))
        else $error("stray write");
    a_fault_pulse: assert property (watchdog_fault |=> !watchdog_fault)
        else $error("long fault");
    a_fault_in_load: assert property (reg_busy |-> !watchdog_fault)
        else $error("fault in load");
    a_supply_copy: assert property (supply_wr |->
        ##2 external_supply_sel == $past(reg_wdata[2], 2)) else $error("supply");
    a_wr_gate: assert property (user_ee_wr_en |-> $past(user_ee_wr_req))
        else $error("write gate");
endmodule

bind supervisor_output_watchdog_logic sowl_assertions i_sowl_assertions (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_busy(reg_busy), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
    .user_ee_wr_req(user_ee_wr_req), .user_ee_wr_en(user_ee_wr_en),
    .external_supply_sel(external_supply_sel), .watchdog_fault(watchdog_fault)
);
`default_nettype wire

// ---- tb/far_side_model.sv ----
// Purpose: nonvolatile copy and supervised processor
// Assumes: core clock
// Notes: copy n holds its low nibble shifted up
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input wire logic core_clk,
    input wire logic nvm_rd,
    input wire logic [7:0] nvm_addr,
    output logic [7:0] nvm_rdata = 8'h00,
    input wire logic kick_en,
    output logic kick
);
    int cnt = 0;
    always @(posedge core_clk) begin
        nvm_rdata <= nvm_rd ? {nvm_addr[3:0], 4'h0} : ~nvm_rdata;
        cnt <= (cnt == 999) ? 0 : cnt + 1;
    end
    assign kick = kick_en && cnt < 4;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the output and watchdog logic
// Assumes: tick of two clocks
// Notes: rows exercise outputs nine and ten
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [7:0] b; logic [2:0][7:0] cfg;
        logic [7:0] uv; logic [4:0] gm; logic o;} row_type;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, ken = 0, busy, nrd, kick, fault;
    logic sg = 1, ext, ueen;
    logic [7:0] ad = 0, wd = 0, uv = 0, rdat, na, ndat, seen;
    logic [4:0] gm = 5'h01;
    logic [9:0] po, pu, oe;
    int failures = 0, checks_done = 0, cycles = 0, faults = 0, idx;
    row_type rows [6] = '{
        '{8'h22, 24'h000001, 8'h01, 5'h01, 1'b0},
        '{8'h25, 24'h000000, 8'hff, 5'h01, 1'b1},
        '{8'h25, 24'h010200, 8'h00, 5'h03, 1'b0},
        '{8'h22, 24'h021080, 8'h80, 5'h01, 1'b1},
        '{8'h25, 24'h002000, 8'h00, 5'h00, 1'b0},
        '{8'h22, 24'h00de00, 8'h00, 5'h00, 1'b1}};
    always #12.5 clk = ~clk;
    supervisor_output_watchdog_logic #(.TICK_CYCLES(2)) i_supervisor_output_watchdog_logic (
        .core_clk(clk), .arst_n(rst_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .reg_busy(busy), .nvm_rd(nrd), .nvm_wr(),
        .nvm_addr(na), .nvm_wdata(), .nvm_rdata(ndat), .undervoltage(uv),
        .general_logic_input(gm[4:1] | {3'h0, kick}), .manual_reset_input_n(gm[0]),
        .supply_good(sg), .reboot_req(1'b0), .sequencer_request(8'h00),
        .user_ee_wr_req(1'b1), .user_ee_wr_en(ueen), .programmable_output_o(po),
        .programmable_output_oe(oe), .programmable_output_pullup(pu),
        .external_supply_sel(ext), .watchdog_fault(fault));
    far_side_model i_far_side_model (.core_clk(clk), .nvm_rd(nrd), .nvm_addr(na),
        .nvm_rdata(ndat), .kick_en(ken), .kick(kick));
    always @(posedge clk) begin
        cycles++;
        faults += int'(fault);
        if (cycles == 60000) print_verdict(1);
    end
    task automatic print_verdict(input int extra);
        failures += extra;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {wr, rd, ad, wd} = {w, !w, a, d};
        @(posedge clk) #1;
        {wr, rd} = 2'b00;
        seen = rdat;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        cyc(8);
        rst_n = 1;
        for (int n = 0; n < 400 && busy !== 1'b0; n++) cyc(1);
        acc(1'b0, 8'h2a, 8'h00);
        chk("load", seen, 8'ha0);
        foreach (rows[k]) begin
            idx = (rows[k].b == 8'h25) ? 9 : 8;
            for (int j = 0; j < 3; j++) acc(1'b1, rows[k].b + 8'(j), rows[k].cfg[j]);
            {uv, gm} = {rows[k].uv, rows[k].gm};
            cyc(12);
            chk("level", 8'(po[idx]), 8'(rows[k].o));
            chk("pullup", 8'(pu[idx]), 8'(!rows[k].cfg[2][0]));
            chk("drive", 8'(oe[idx]), 8'(!rows[k].o));
            {uv, gm} = 13'h0001;
            cyc(60);
        end
        acc(1'b1, 8'h2e, 8'h01);
        acc(1'b1, 8'h24, 8'h55);
        acc(1'b0, 8'h24, 8'h00);
        chk("locked", seen, 8'h00);
        acc(1'b1, 8'h2e, 8'h00);
        acc(1'b1, 8'hb0, 8'h12);
        acc(1'b1, 8'h24, 8'h02);
        acc(1'b0, 8'h24, 8'h00);
        chk("unlocked", seen, 8'h02);
        acc(1'b1, 8'h2e, 8'h06);
        sg = 0;
        cyc(8);
        chk("supply", 8'({ext, ueen}), 8'h02);
        sg = 1;
        cyc(8);
        chk("wr gate", 8'(ueen), 8'h01);
        acc(1'b1, 8'h2e, 8'h00);
        acc(1'b1, 8'h23, 8'h01);
        acc(1'b1, 8'h29, 8'h40);
        ken = 1;
        acc(1'b1, 8'h2a, 8'h48);
        cyc(20000);
        chk("kicked", 8'(faults), 8'h00);
        ken = 0;
        for (int n = 0; n < 4200 && faults == 0; n++) cyc(1);
        chk("normal", 8'(faults), 8'h01);
        cyc(3);
        chk("wd out", 8'(po[8]), 8'h01);
        cyc(12000);
        chk("restart", 8'(faults), 8'h01);
        cyc(4500);
        chk("initial", 8'(faults), 8'h02);
        print_verdict(0);
    end
endmodule
`default_nettype wire
